// >>> hw/tif_ctl_if.sv
// Purpose: carries prescaler and periodic timebase signals between the timer flag modules
// Assumes: all signals belong to clk
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface tif_ctl_if;
	logic       pr_wr;
	logic [1:0] pr_wdata;
	logic       normal_mode;
	logic [1:0] pr_sel;
	logic       presc_tick;
	logic [1:0] rate;
	logic       rti_timeout;

	modport top   (output pr_wr, pr_wdata, normal_mode, rate, input pr_sel, presc_tick, rti_timeout);
	modport presc (input pr_wr, pr_wdata, normal_mode, output pr_sel, presc_tick);
	modport rti   (input rate, output rti_timeout);
endinterface
`default_nettype wire

// >>> hw/tif_pkg.sv
// Purpose: shared constants and types for the timer flag, mask, prescaler and periodic logic
// Assumes: one clock, the E clock; registers on a plain address port
// Notes: offsets are the byte addresses seen on the register port
package tif_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [15:0] TIF_OFS_MASK_ONE  = 16'h1022;
	localparam logic [15:0] TIF_OFS_FLAGS_ONE = 16'h1023;
	localparam logic [15:0] TIF_OFS_MASK_TWO  = 16'h1024;
	localparam logic [15:0] TIF_OFS_FLAGS_TWO = 16'h1025;

	localparam logic [7:0]  TIF_RST_MASK_ONE  = 8'h00;
	localparam logic [7:0]  TIF_RST_FLAGS_ONE = 8'h00;
	localparam logic [3:0]  TIF_RST_ENABLES   = 4'h0;
	localparam logic [3:0]  TIF_RST_FLAGS_TWO = 4'h0;
	localparam logic [1:0]  TIF_RST_PRESCALE  = 2'h0;
	localparam logic [7:0]  TIF_RDATA_IDLE    = 8'h00;
	localparam logic [3:0]  TIF_ZERO_NIBBLE   = 4'h0;
	localparam logic [1:0]  TIF_ZERO_PAIR     = 2'h0;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int TIF_BIT_CH45      = 3;
	localparam int TIF_BIT_OVERFLOW  = 7;
	localparam int TIF_BIT_PERIODIC  = 6;
	localparam int TIF_IDX_OVERFLOW  = 3;
	localparam int TIF_IDX_PERIODIC  = 2;
	localparam int TIF_IDX_ACC_OVF   = 1;
	localparam int TIF_IDX_ACC_EDGE  = 0;
	localparam int TIF_PR_W          = 2;
	localparam int TIF_RATE_W        = 2;

	// ****************************************************************
	// counts
	// ****************************************************************
	localparam logic [15:0] TIF_CNT_ALL_ONES  = 16'hffff;
	localparam logic [15:0] TIF_CNT_ZERO      = 16'h0000;
	localparam int          TIF_PR_WINDOW     = 64;
	localparam int          TIF_WIN_W         = 7;
	localparam int          TIF_RTI_BASE_LOG2 = 13;
	localparam int          TIF_RTI_CNT_W     = 16;
	localparam int          TIF_DIV_W         = 4;
	localparam logic [3:0]  TIF_DIV_MASK_1    = 4'h0;
	localparam logic [3:0]  TIF_DIV_MASK_4    = 4'h3;
	localparam logic [3:0]  TIF_DIV_MASK_8    = 4'h7;
	localparam logic [3:0]  TIF_DIV_MASK_16   = 4'hf;

	typedef enum logic {TIF_PR_OPEN, TIF_PR_LOCKED} tif_pr_state_t;

endpackage

// >>> hw/tif_presc.sv
// Purpose: write-once prescaler select and the counter clock enable it produces
// Assumes: window counted from reset release on clk
// Notes: in special modes the select may be written at any time
`timescale 1ns/1ps
`default_nettype none
module tif_presc (
	input  wire logic clk,
	input  wire logic rstn,
	tif_ctl_if.presc  ctl
);
	tif_pkg::tif_pr_state_t         state_q;
	logic [tif_pkg::TIF_WIN_W-1:0] win_q;
	logic [tif_pkg::TIF_DIV_W-1:0] div_q;
	logic [tif_pkg::TIF_DIV_W-1:0] dmask;
	logic [1:0]                    pr_q;
	logic                          tick_q;
	logic                          win_open;
	logic                          accept;

	function automatic logic [3:0] div_mask(input logic [1:0] sel);
		case (sel)
			2'h0:    div_mask = tif_pkg::TIF_DIV_MASK_1;
			2'h1:    div_mask = tif_pkg::TIF_DIV_MASK_4;
			2'h2:    div_mask = tif_pkg::TIF_DIV_MASK_8;
			default: div_mask = tif_pkg::TIF_DIV_MASK_16;
		endcase
	endfunction

	assign win_open = win_q < tif_pkg::TIF_WIN_W'(tif_pkg::TIF_PR_WINDOW);
	assign accept   = ctl.pr_wr && (!ctl.normal_mode || (state_q == tif_pkg::TIF_PR_OPEN && win_open));
	assign dmask    = div_mask(pr_q);

	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			win_q <= '0;
		else if (win_open)
			win_q <= win_q + 1'b1;

	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			state_q <= tif_pkg::TIF_PR_OPEN;
			pr_q    <= tif_pkg::TIF_RST_PRESCALE;
		end
		else if (accept)
		begin
			pr_q <= ctl.pr_wdata;
			if (ctl.normal_mode)
				state_q <= tif_pkg::TIF_PR_LOCKED;
		end

	// divide by 1, 4, 8 or 16
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end
		else
		begin
			div_q  <= div_q + 1'b1;
			tick_q <= (div_q & dmask) == dmask;
		end

	assign ctl.pr_sel     = pr_q;
	assign ctl.presc_tick = tick_q;

	AST_PR_LOCKED: assert property (@(posedge clk) disable iff (!rstn)
		(ctl.normal_mode && state_q == tif_pkg::TIF_PR_LOCKED && ctl.pr_wr) |=> $stable(pr_q))
		else $error("prescale select changed after lock");

	AST_PR_LATE: assert property (@(posedge clk) disable iff (!rstn)
		(ctl.normal_mode && !win_open && ctl.pr_wr) |=> $stable(pr_q))
		else $error("prescale select changed after its window");
endmodule
`default_nettype wire

// >>> hw/tif_rti.sv
// Purpose: free-running periodic timebase with selectable period
// Assumes: BASE_LOG2 plus 3 does not exceed the counter width
// Notes: only reset stops it
`timescale 1ns/1ps
`default_nettype none
module tif_rti #(
	parameter int BASE_LOG2 = tif_pkg::TIF_RTI_BASE_LOG2
) (
	input  wire logic clk,
	input  wire logic rstn,
	tif_ctl_if.rti    ctl
);
	localparam int W = tif_pkg::TIF_RTI_CNT_W;
	logic [W-1:0] cnt_q;
	logic [W-1:0] tap;
	logic         tout_q;

	assign tap = W'((32'd1 << (BASE_LOG2 + int'(ctl.rate))) - 32'd1);

	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			cnt_q  <= '0;
			tout_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_q + 1'b1;
			tout_q <= (cnt_q & tap) == tap;
		end

	assign ctl.rti_timeout = tout_q;
endmodule
`default_nettype wire

// >>> hw/tif_timer_flags.sv
// Purpose: timer interrupt masks, event flags, write-once prescaler and periodic interrupt
// Assumes: event inputs are one-cycle pulses synchronous to clk, which is the E clock
// Notes: rdata is valid only in the cycle after a read strobe
`timescale 1ns/1ps
`default_nettype none
module tif_timer_flags #(
	parameter int RTI_BASE_LOG2 = tif_pkg::TIF_RTI_BASE_LOG2
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	input  wire logic [3:0]  compare_hit,
	input  wire logic        compare_five_hit,
	input  wire logic        capture_four_edge,
	input  wire logic [2:0]  capture_edge,
	input  wire logic [15:0] free_running_counter,
	input  wire logic        accum_overflow_event,
	input  wire logic        accum_edge_event,
	input  wire logic        channel45_select,
	input  wire logic [1:0]  periodic_rate_select,
	input  wire logic        normal_mode,
	output logic      [7:0]  irq_one,
	output logic      [3:0]  irq_two,
	output logic      [1:0]  prescale_select,
	output logic             prescale_tick,
	output logic             periodic_timeout
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	tif_ctl_if ctl ();

	logic [7:0]  mask_one_q;
	logic [7:0]  flags_one_q;
	logic [7:0]  flags_one_d;
	logic [3:0]  enables_q;
	logic [3:0]  flags_two_q;
	logic [3:0]  flags_two_d;
	logic [15:0] prev_cnt_q;
	logic [7:0]  rdata_q;
	logic [7:0]  rd_mux;
	logic [7:0]  set_one;
	logic [7:0]  clr_one;
	logic [3:0]  set_two;
	logic [3:0]  clr_two;
	logic        ch45_event;
	logic        rollover;
	logic        wr_m1;
	logic        wr_f1;
	logic        wr_m2;
	logic        wr_f2;

	function automatic logic reg_hit(input logic [15:0] a, input logic [15:0] ofs);
		reg_hit = (a == ofs);
	endfunction

	// ****************************************************************
	// submodules
	// ****************************************************************
	tif_presc u_presc (
		.clk  (clk),
		.rstn (rstn),
		.ctl  (ctl.presc)
	);

	tif_rti #(
		.BASE_LOG2 (RTI_BASE_LOG2)
	) u_rti (
		.clk  (clk),
		.rstn (rstn),
		.ctl  (ctl.rti)
	);

	// ****************************************************************
	// write decode
	// ****************************************************************
	assign wr_m1 = wr && reg_hit(addr, tif_pkg::TIF_OFS_MASK_ONE);
	assign wr_f1 = wr && reg_hit(addr, tif_pkg::TIF_OFS_FLAGS_ONE);
	assign wr_m2 = wr && reg_hit(addr, tif_pkg::TIF_OFS_MASK_TWO);
	assign wr_f2 = wr && reg_hit(addr, tif_pkg::TIF_OFS_FLAGS_TWO);

	assign ctl.pr_wr       = wr_m2;
	assign ctl.pr_wdata    = wdata[tif_pkg::TIF_PR_W-1:0];
	assign ctl.normal_mode = normal_mode;
	assign ctl.rate        = periodic_rate_select;

	// ****************************************************************
	// mask registers
	// ****************************************************************
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			mask_one_q <= tif_pkg::TIF_RST_MASK_ONE;
		else if (wr_m1)
			mask_one_q <= wdata;

	// only the upper nibble is stored here; prescaler bits live in the prescaler
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			enables_q <= tif_pkg::TIF_RST_ENABLES;
		else if (wr_m2)
			enables_q <= wdata[7:4];

	// ****************************************************************
	// event sources
	// ****************************************************************
	// shared channel follows the select bit
	assign ch45_event = channel45_select ? capture_four_edge : compare_five_hit;

	// bit 7..4 compare 1..4, bit 3 shared channel, bit 2..0 capture 1..3
	assign set_one = {compare_hit, ch45_event, capture_edge};
	assign clr_one = wr_f1 ? wdata : tif_pkg::TIF_RDATA_IDLE;

	assign rollover = (prev_cnt_q == tif_pkg::TIF_CNT_ALL_ONES)
		&& (free_running_counter == tif_pkg::TIF_CNT_ZERO);

	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			prev_cnt_q <= tif_pkg::TIF_CNT_ZERO;
		else
			prev_cnt_q <= free_running_counter;

	// order matches the upper nibble of the second flag register
	assign set_two = {rollover, ctl.rti_timeout, accum_overflow_event, accum_edge_event};
	assign clr_two = wr_f2 ? wdata[7:4] : tif_pkg::TIF_ZERO_NIBBLE;

	// ****************************************************************
	// flag update: set beats clear
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_one
			assign flags_one_d[gi] = set_one[gi] | (flags_one_q[gi] & ~clr_one[gi]);
		end
		for (gi = 0; gi < 4; gi++)
		begin : g_two
			assign flags_two_d[gi] = set_two[gi] | (flags_two_q[gi] & ~clr_two[gi]);
		end
	endgenerate

	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			flags_one_q <= tif_pkg::TIF_RST_FLAGS_ONE;
		else
			flags_one_q <= flags_one_d;

	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			flags_two_q <= tif_pkg::TIF_RST_FLAGS_TWO;
		else
			flags_two_q <= flags_two_d;

	// ****************************************************************
	// interrupt requests
	// ****************************************************************
	assign irq_one = flags_one_q & mask_one_q;
	assign irq_two = flags_two_q & enables_q;

	// ****************************************************************
	// read path
	// ****************************************************************
	always_comb
	begin
		if (reg_hit(addr, tif_pkg::TIF_OFS_MASK_ONE))
			rd_mux = mask_one_q;
		else if (reg_hit(addr, tif_pkg::TIF_OFS_FLAGS_ONE))
			rd_mux = flags_one_q;
		else if (reg_hit(addr, tif_pkg::TIF_OFS_MASK_TWO))
			rd_mux = {enables_q, tif_pkg::TIF_ZERO_PAIR, ctl.pr_sel};
		else if (reg_hit(addr, tif_pkg::TIF_OFS_FLAGS_TWO))
			rd_mux = {flags_two_q, tif_pkg::TIF_ZERO_NIBBLE};
		else
			rd_mux = tif_pkg::TIF_RDATA_IDLE;
	end

	// data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			rdata_q <= tif_pkg::TIF_RDATA_IDLE;
		else if (rd)
			rdata_q <= rd_mux;
		else
			rdata_q <= tif_pkg::TIF_RDATA_IDLE;

	assign rdata            = rdata_q;
	assign prescale_select  = ctl.pr_sel;
	assign prescale_tick    = ctl.presc_tick;
	assign periodic_timeout = ctl.rti_timeout;

	// ****************************************************************
	// checks
	// ****************************************************************
	localparam int RTI_FIRST = 1 << RTI_BASE_LOG2;
	logic [16:0] since_q;
	logic        seen_q;

	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			since_q <= '0;
			seen_q  <= 1'b0;
		end
		else
		begin
			if (!since_q[16])
				since_q <= since_q + 1'b1;
			if (flags_two_q[tif_pkg::TIF_IDX_PERIODIC])
				seen_q <= 1'b1;
		end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_cap4_sel;
		channel45_select && capture_four_edge;
	endsequence

	sequence s_clr_ch45_only;
		wr_f1 && wdata[tif_pkg::TIF_BIT_CH45] && !ch45_event;
	endsequence

	sequence s_quiet_period;
		!ctl.rti_timeout [*4];
	endsequence

	AST_CH45_CAPTURE: assert property (
		s_cap4_sel |=> flags_one_q[tif_pkg::TIF_BIT_CH45])
		else $error("capture 4 did not set shared flag");

	AST_CH45_IGNORED: assert property (
		(channel45_select && !capture_four_edge) ##0 s_clr_ch45_only
		|=> !flags_one_q[tif_pkg::TIF_BIT_CH45])
		else $error("compare 5 set shared flag while capture 4 selected");

	AST_CAPTURE_IRQ: assert property (
		(capture_edge[0] && mask_one_q[0] && !wr_m1) |=> irq_one[0])
		else $error("capture 3 request missing");

	AST_W1C_ZERO: assert property (
		(wr_f1 && wdata == tif_pkg::TIF_RDATA_IDLE) |=> (flags_one_q | ~$past(flags_one_q)) == 8'hff)
		else $error("writing zero cleared a flag");

	AST_SET_WINS: assert property (
		(wr_f1 && wdata[tif_pkg::TIF_BIT_OVERFLOW] && compare_hit[3]) |=> flags_one_q[7])
		else $error("event lost against clear");

	AST_IRQ_DROPS: assert property (
		(wr_f1 && wdata[7] && !compare_hit[3]) |=> !irq_one[7])
		else $error("request held after flag clear");

	AST_OVERFLOW: assert property (
		rollover |=> flags_two_q[tif_pkg::TIF_IDX_OVERFLOW] ##0 (irq_two[3] == enables_q[3]))
		else $error("overflow flag or request wrong");

	AST_RSVD_READ: assert property (
		(rd && reg_hit(addr, tif_pkg::TIF_OFS_FLAGS_TWO)) |=> rdata[3:0] == tif_pkg::TIF_ZERO_NIBBLE)
		else $error("reserved bits read nonzero");

	AST_RTI_FLAG: assert property (
		(ctl.rti_timeout && !enables_q[tif_pkg::TIF_IDX_PERIODIC]) |=> flags_two_q[tif_pkg::TIF_IDX_PERIODIC])
		else $error("periodic flag not set while disabled");

	AST_RTI_FIRST: assert property (
		(ctl.rti_timeout && !seen_q && !flags_two_q[tif_pkg::TIF_IDX_PERIODIC]) |-> since_q >= 17'(RTI_FIRST))
		else $error("periodic time-out before first full period");

	AST_RTI_SPACING: assert property (
		ctl.rti_timeout |=> s_quiet_period)
		else $error("periodic time-outs too close");

	AST_CH45_COMPARE: assert property (
		(!channel45_select && compare_five_hit) |=> flags_one_q[tif_pkg::TIF_BIT_CH45])
		else $error("compare 5 did not set shared flag");

	AST_CH45_NO_COMPARE: assert property (
		(channel45_select && compare_five_hit && !capture_four_edge && !flags_one_q[tif_pkg::TIF_BIT_CH45])
		|=> !flags_one_q[tif_pkg::TIF_BIT_CH45])
		else $error("compare 5 reached shared flag under capture select");

	AST_CH45_NO_CAPTURE: assert property (
		(!channel45_select && capture_four_edge && !compare_five_hit && !flags_one_q[tif_pkg::TIF_BIT_CH45])
		|=> !flags_one_q[tif_pkg::TIF_BIT_CH45])
		else $error("capture 4 reached shared flag under compare select");

	AST_COMPARE_SET: assert property (
		(|compare_hit) |=> (flags_one_q[7:4] & $past(compare_hit)) == $past(compare_hit))
		else $error("compare match did not set its flag");

	AST_CAPTURE_SET: assert property (
		(|capture_edge) |=> (flags_one_q[2:0] & $past(capture_edge)) == $past(capture_edge))
		else $error("capture edge did not set its flag");

	AST_W1C_ONE: assert property (
		(wr_f1 && set_one == '0) |=> (flags_one_q & $past(wdata)) == '0)
		else $error("written one left a first flag set");

	AST_W1C_TWO: assert property (
		(wr_f2 && set_two == '0) |=> (flags_two_q & $past(wdata[7:4])) == '0)
		else $error("written one left a second flag set");

	AST_PERIODIC_SET: assert property (
		ctl.rti_timeout |=> flags_two_q[tif_pkg::TIF_IDX_PERIODIC])
		else $error("time-out did not set periodic flag");

	AST_PERIODIC_IRQ: assert property (
		(ctl.rti_timeout && enables_q[tif_pkg::TIF_IDX_PERIODIC] && !wr_m2)
		|=> irq_two[tif_pkg::TIF_IDX_PERIODIC])
		else $error("enabled periodic flag gave no request");

	AST_PERIODIC_BLOCKED: assert property (
		(ctl.rti_timeout && !enables_q[tif_pkg::TIF_IDX_PERIODIC] && !wr_m2)
		|=> !irq_two[tif_pkg::TIF_IDX_PERIODIC])
		else $error("disabled periodic flag gave a request");

	AST_ACC_OVF_FLAG: assert property (
		accum_overflow_event |=> flags_two_q[tif_pkg::TIF_IDX_ACC_OVF])
		else $error("accumulator overflow flag not set");

	AST_ACC_EDGE_FLAG: assert property (
		accum_edge_event |=> flags_two_q[tif_pkg::TIF_IDX_ACC_EDGE])
		else $error("accumulator edge flag not set");

endmodule
`default_nettype wire

// >>> testbench/tif_timer_flags_test.sv
// Purpose: self-checking bench for the timer masks, flags, prescaler and periodic interrupt
// Assumes: periodic base shortened to 2^3 clocks through RTI_BASE_LOG2
// Notes: inputs change by non-blocking assignment at the rising edge
`timescale 1ns/1ps
`default_nettype none
module tif_timer_flags_test;
	localparam int          B  = 3;
	localparam logic [15:0] A1 = tif_pkg::TIF_OFS_MASK_ONE;
	localparam logic [15:0] F1 = tif_pkg::TIF_OFS_FLAGS_ONE;
	localparam logic [15:0] A2 = tif_pkg::TIF_OFS_MASK_TWO;
	localparam logic [15:0] F2 = tif_pkg::TIF_OFS_FLAGS_TWO;

	logic        clk                  = 1'b0;
	logic        rstn                 = 1'b0;
	logic [15:0] addr                 = 16'h0000;
	logic [7:0]  wdata                = 8'h00;
	logic        wr                   = 1'b0;
	logic        rd                   = 1'b0;
	logic [7:0]  rdata;
	logic [3:0]  compare_hit          = 4'h0;
	logic        compare_five_hit     = 1'b0;
	logic        capture_four_edge    = 1'b0;
	logic [2:0]  capture_edge         = 3'h0;
	logic [15:0] frc                  = 16'h0000;
	logic        accum_overflow_event = 1'b0;
	logic        accum_edge_event     = 1'b0;
	logic        channel45_select     = 1'b0;
	logic [1:0]  periodic_rate_select = 2'h0;
	logic        normal_mode          = 1'b1;
	logic [7:0]  irq_one;
	logic [3:0]  irq_two;
	logic [1:0]  prescale_select;
	logic        prescale_tick;
	logic        periodic_timeout;
	int          mismatches           = 0;
	int          n_tests              = 0;
	int          cycles               = 0;
	int          gap                  = 0;
	int          last_gap             = 0;
	int          first_gap            = 0;
	int          n_to                 = 0;

	tif_timer_flags #(.RTI_BASE_LOG2(B)) DUT (
		.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.compare_hit(compare_hit), .compare_five_hit(compare_five_hit),
		.capture_four_edge(capture_four_edge), .capture_edge(capture_edge),
		.free_running_counter(frc), .accum_overflow_event(accum_overflow_event),
		.accum_edge_event(accum_edge_event), .channel45_select(channel45_select),
		.periodic_rate_select(periodic_rate_select), .normal_mode(normal_mode),
		.irq_one(irq_one), .irq_two(irq_two), .prescale_select(prescale_select),
		.prescale_tick(prescale_tick), .periodic_timeout(periodic_timeout)
	);

	always #50 clk = ~clk;

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic end_sim();
		if (mismatches == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask

	// order: compare 1..4, compare 5, capture 4, capture 1..3
	task automatic ev(input logic [8:0] v);
		@(posedge clk);
		{compare_hit, compare_five_hit, capture_four_edge, capture_edge} <= v;
		@(posedge clk);
		{compare_hit, compare_five_hit, capture_four_edge, capture_edge} <= 9'h000;
		#1;
	endtask

	task automatic ticks(input int n, output int k);
		k = 0;
		repeat (n)
		begin
			@(posedge clk);
			if (prescale_tick === 1'b1)
				k++;
		end
	endtask

	task automatic wait_to();
		@(posedge clk);
		while (periodic_timeout !== 1'b1)
			@(posedge clk);
		#1;
	endtask

	// ****************************************************************
	// periodic gap monitor and hang limit
	// ****************************************************************
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (!rstn)
		begin
			gap <= 0;
			n_to <= 0;
		end
		else if (periodic_timeout === 1'b1)
		begin
			if (n_to == 0)
				first_gap <= gap + 1;
			last_gap <= gap + 1;
			gap <= 0;
			n_to <= n_to + 1;
		end
		else
			gap <= gap + 1;
		if (cycles == 5000)
		begin
			mismatches++;
			end_sim();
		end
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		int         k;
		logic [7:0] fb;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rd_chk(F2, 8'h00);
		rd_chk(F1, 8'h00);
		rd_chk(A1, 8'h00);
		rd_chk(A2, 8'h00);
		rd_chk(16'h1026, 8'h00);
		ticks(8, k);
		chk(8'(k), 8'h08);
		wr_reg(A2, 8'hfe);
		rd_chk(A2, 8'hf2);
		wr_reg(A2, 8'hf1);
		rd_chk(A2, 8'hf2);
		chk(8'(prescale_select), 8'h02);
		ticks(32, k);
		chk(8'(k), 8'h04);
		// a full period from release, then the registered time-out seen one edge later
		chk(8'(first_gap), 8'((1 << B) + 1));
		wr_reg(16'h1026, 8'hff);
		rd_chk(A1, 8'h00);
		for (int r = 0; r < 4; r++)
		begin
			@(posedge clk);
			periodic_rate_select <= 2'(r);
			wait_to();
			wait_to();
			chk(8'(last_gap), 8'((1 << B) << r));
		end
		wait_to();
		rd_chk(F2, 8'h40);
		chk(8'(irq_two), 8'h04);
		wr_reg(A2, 8'hb0);
		chk(8'(irq_two), 8'h00);
		rd_chk(F2, 8'h40);
		wr_reg(F2, 8'h40);
		rd_chk(F2, 8'h00);
		wait_to();
		chk(8'(last_gap), 8'h40);
		@(posedge clk);
		frc <= 16'hffff;
		@(posedge clk);
		frc <= 16'h0000;
		@(posedge clk);
		accum_overflow_event <= 1'b1;
		accum_edge_event <= 1'b1;
		@(posedge clk);
		accum_overflow_event <= 1'b0;
		accum_edge_event <= 1'b0;
		#1;
		chk(8'(irq_two), 8'h0b);
		wr_reg(F2, 8'h80);
		chk(8'(irq_two), 8'h03);
		wr_reg(A2, 8'h00);
		chk(8'(irq_two), 8'h00);
		wr_reg(A1, 8'hff);
		for (int i = 0; i < 8; i++)
		begin
			fb = 8'h01 << i;
			ev({fb[7:3], 1'b0, fb[2:0]});
			chk(irq_one, fb);
			wr_reg(F1, ~fb);
			rd_chk(F1, fb);
			wr_reg(F1, fb);
			rd_chk(F1, 8'h00);
		end
		@(posedge clk);
		channel45_select <= 1'b1;
		ev(9'h010);
		chk(irq_one, 8'h00);
		ev(9'h008);
		chk(irq_one, 8'h08);
		wr_reg(F1, 8'h08);
		@(posedge clk);
		channel45_select <= 1'b0;
		ev(9'h008);
		chk(irq_one, 8'h00);
		wr_reg(A1, 8'h7f);
		ev(9'h100);
		chk(irq_one, 8'h00);
		rd_chk(F1, 8'h80);
		@(posedge clk);
		compare_hit <= 4'h8;
		addr <= F1;
		wdata <= 8'h80;
		wr <= 1'b1;
		@(posedge clk);
		compare_hit <= 4'h0;
		wr <= 1'b0;
		rd_chk(F1, 8'h80);
		wr_reg(A1, 8'hff);
		repeat (5) @(posedge clk);
		#1;
		chk(irq_one, 8'h80);
		@(posedge clk);
		normal_mode <= 1'b0;
		// divide ratios 1, 4, 8 and 16 for codes 0 to 3
		for (int p = 0; p < 4; p++)
		begin
			wr_reg(A2, 8'(p));
			chk(8'(prescale_select), 8'(p));
			@(posedge clk);
			ticks(32, k);
			chk(8'(k), 8'(32 / (p == 0 ? 1 : (2 << p))));
		end
		@(posedge clk);
		rstn <= 1'b0;
		normal_mode <= 1'b1;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		#1;
		chk(irq_one, 8'h00);
		repeat (70) @(posedge clk);
		wr_reg(A2, 8'h03);
		rd_chk(A2, 8'h00);
		chk(8'(prescale_select), 8'h00);
		end_sim();
	end
endmodule
`default_nettype wire
